// ===== logic/cwcs_top.sv
/*
  Configuration word decode, system clock source select and divider, start-up
  flags, code protection gate and user ID store, with an APB register slave.
  Assumes the configuration strap word is steady around reset release, the
  external clock pin is asynchronous and slower than a quarter of REF_CLK, and
  SLEEP_MODE and the memory access requests come from logic on REF_CLK.
*/
`timescale 1ns/1ps

// What this block does
// - Source bit 1 picks external pin clock, 0 picks internal oscillator and frees pin.
// - Any reset loads frequency select with code 110, the 8 MHz rate.
// - Frequency select divides 16 MHz to 8 rates including 31 kHz oscillator.
// - Switching between high-frequency divider outputs needs no start-up delay.
// - Secondary high-frequency clock starts first, accurate primary clock afterwards.
// - Read-only ready flag sets when the secondary clock has started.
// - Read-only stable flag sets once the primary clock is stable.
// - Watchdog field: 11 always, 10 running only, 01 software bit, 00 off.
// - Brown-out field decodes likewise; software bit counts only under code 01.
// - Power-up timer bit is active low: 1 disables, 0 enables.
// - Brown-out enable never enables the power-up timer by itself.
// - Code protect low blocks external memory access; external reads return zero.
// - Internal reads unaffected; one code protect bit gates external reads and writes.
// - Apart from reset, code protection clears only through a bulk erase of the device.
// - Two-bit write protect field sizes the region blocked from self-writes.
// - Four user ID words are readable and writable in normal execution.
// - In external mode the pin's logic-level clock drives the system clock.
module cwcs_top
  import cwcs_pkg::*;
#(
  parameter int PRI_CYC = PRI_STABLE_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [13:0] CFG_STRAP,
  input  wire logic        BULK_ERASE,
  input  wire logic        CLOCK_INPUT_PIN,
  input  wire logic        SLEEP_MODE,
  input  wire logic        EXT_RD_REQ,
  input  wire logic [13:0] EXT_RD_MEM,
  input  wire logic        EXT_WR_REQ,
  output logic      [13:0] EXT_RD_DATA,
  output logic             EXT_WR_GO,
  output logic             SYS_CLK_TICK,
  output logic             CLOCK_INPUT_PIN_IS_GPIO,
  output logic             WATCHDOG_EN,
  output logic             BROWNOUT_EN,
  output logic             POWERUP_TIMER_EN,
  output logic      [1:0]  WRITE_PROTECT_SIZE
);

  // Shared decode of a two-bit enable field against the sleep state and software bit.
  function automatic logic field_enable(input logic [1:0] fld, input logic sw, input logic slp);
    logic en;
    en = 1'b0;
    case (fld)
      EN_ALWAYS:   en = 1'b1;
      EN_RUN_ONLY: en = ~slp;
      EN_SOFTWARE: en = sw;
      default:     en = 1'b0;
    endcase
    return en;
  endfunction

  typedef enum logic [1:0] {ST_SEC_WAIT, ST_PRI_WAIT, ST_RUN} cwcs_start_t;

  // ---------------- Register and configuration state ----------------
  logic [13:0] cfg_q, cfg_d;
  logic        cfg_load_q, cfg_load_d;
  logic [2:0]  fsel_q, fsel_d;
  logic        sw_wdt_q, sw_wdt_d;
  logic        sw_bor_q, sw_bor_d;
  logic [13:0] uid_q [USER_ID_NUM];
  logic [13:0] uid_d [USER_ID_NUM];
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        wdt_q, wdt_d, bor_q, bor_d, pwrt_q, pwrt_d;
  logic [13:0] ext_rd_q, ext_rd_d;
  logic        ready_flag, stable_flag;

  logic apb_setup, apb_wr;
  logic mapped;
  logic [1:0] uid_idx;
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE;
  assign uid_idx   = PADDR[3:2];
  assign mapped    = (PADDR == OFS_CFG_WORD) || (PADDR == OFS_OSC_CTRL) ||
                     (PADDR == OFS_SW_ENABLE) ||
                     (PADDR >= OFS_USER_ID0 && PADDR <= OFS_USER_ID3 && PADDR[1:0] == 2'h0);

  // Next values for registers, decoded enables and the protected read path.
  always_comb begin
    cfg_d      = cfg_q;
    cfg_load_d = 1'b0;
    fsel_d     = fsel_q;
    sw_wdt_d   = sw_wdt_q;
    sw_bor_d   = sw_bor_q;
    uid_d      = uid_q;
    rdata_d    = rdata_q;
    err_d      = err_q;
    // The strap is caught one edge after release, never under the reset itself.
    if (cfg_load_q) begin
      cfg_d = CFG_STRAP;
    end
    // Apart from reset, only a bulk erase returns the word, code protect included, to erased ones.
    if (BULK_ERASE) begin
      cfg_d = CFG_ERASED;
    end
    if (apb_wr && PADDR == OFS_OSC_CTRL) begin
      fsel_d = PWDATA[OSC_FSEL_LO +: 3];
    end
    if (apb_wr && PADDR == OFS_SW_ENABLE) begin
      sw_wdt_d = PWDATA[SW_WDT_BIT];
      sw_bor_d = PWDATA[SW_BOR_BIT];
    end
    if (apb_wr && PADDR >= OFS_USER_ID0 && PADDR <= OFS_USER_ID3 && mapped) begin
      uid_d[uid_idx] = PWDATA[13:0];
    end
    // Read data and error are captured in the setup cycle so they stand in the access phase.
    if (apb_setup) begin
      err_d   = ~mapped;
      rdata_d = 32'h0000_0000;
      if (PADDR == OFS_CFG_WORD) begin
        rdata_d[13:0] = cfg_q;
      end else if (PADDR == OFS_OSC_CTRL) begin
        rdata_d[OSC_FSEL_LO +: 3]  = fsel_q;
        rdata_d[OSC_READY_BIT]     = ready_flag;
        rdata_d[OSC_STABLE_BIT]    = stable_flag;
      end else if (PADDR == OFS_SW_ENABLE) begin
        rdata_d[SW_WDT_BIT] = sw_wdt_q;
        rdata_d[SW_BOR_BIT] = sw_bor_q;
      end else if (mapped) begin
        rdata_d[13:0] = uid_q[uid_idx];
      end
    end
    wdt_d  = field_enable(cfg_q[CFG_WDT_LO +: 2], sw_wdt_q, SLEEP_MODE);
    bor_d  = field_enable(cfg_q[CFG_BOR_LO +: 2], sw_bor_q, SLEEP_MODE);
    // The timer enable looks at its own bit only, whatever brown-out does.
    pwrt_d = ~cfg_q[CFG_PWRT_N];
    // Internal program reads bypass this gate entirely; only the external port is masked.
    ext_rd_d = ext_rd_q;
    if (EXT_RD_REQ) begin
      ext_rd_d = cfg_q[CFG_CP_N] ? EXT_RD_MEM : 14'h0000;
    end
  end

  // Register stage; the reset value of the frequency select is the 8 MHz code.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q      <= CFG_ERASED;
      cfg_load_q <= 1'b1;
      fsel_q     <= FSEL_DEFAULT;
      sw_wdt_q   <= 1'b0;
      sw_bor_q   <= 1'b0;
      for (int i = 0; i < USER_ID_NUM; i++) begin
        uid_q[i] <= 14'h0000;
      end
      rdata_q    <= 32'h0000_0000;
      err_q      <= 1'b0;
      wdt_q      <= 1'b0;
      bor_q      <= 1'b0;
      pwrt_q     <= 1'b0;
      ext_rd_q   <= 14'h0000;
    end else begin
      cfg_q      <= cfg_d;
      cfg_load_q <= cfg_load_d;
      fsel_q     <= fsel_d;
      sw_wdt_q   <= sw_wdt_d;
      sw_bor_q   <= sw_bor_d;
      uid_q      <= uid_d;
      rdata_q    <= rdata_d;
      err_q      <= err_d;
      wdt_q      <= wdt_d;
      bor_q      <= bor_d;
      pwrt_q     <= pwrt_d;
      ext_rd_q   <= ext_rd_d;
    end
  end

  assign PREADY             = 1'b1;
  assign PRDATA             = rdata_q;
  assign PSLVERR            = err_q & PSEL & PENABLE;
  assign WATCHDOG_EN        = wdt_q;
  assign BROWNOUT_EN        = bor_q;
  assign POWERUP_TIMER_EN   = pwrt_q;
  assign EXT_RD_DATA        = ext_rd_q;
  assign EXT_WR_GO          = EXT_WR_REQ & cfg_q[CFG_CP_N];
  assign WRITE_PROTECT_SIZE = cfg_q[CFG_WRT_LO +: 2];
  assign CLOCK_INPUT_PIN_IS_GPIO      = ~cfg_q[CFG_OSC_SRC];

  // ---------------- Oscillator start-up sequence ----------------
  cwcs_start_t st_q, st_d;
  logic [31:0] st_cnt_q, st_cnt_d;

  // The fast secondary clock is reported first; the accurate primary follows.
  always_comb begin
    st_d     = st_q;
    st_cnt_d = st_cnt_q + 32'd1;
    case (st_q)
      ST_SEC_WAIT: begin
        if (st_cnt_q == 32'(SEC_START_CYC - 1)) begin
          st_d     = ST_PRI_WAIT;
          st_cnt_d = 32'd0;
        end
      end
      ST_PRI_WAIT: begin
        if (st_cnt_q == 32'(PRI_CYC - 1)) begin
          st_d     = ST_RUN;
          st_cnt_d = 32'd0;
        end
      end
      ST_RUN:  st_cnt_d = 32'd0;
      default: st_d = ST_SEC_WAIT;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q     <= ST_SEC_WAIT;
      st_cnt_q <= 32'd0;
    end else begin
      st_q     <= st_d;
      st_cnt_q <= st_cnt_d;
    end
  end

  assign ready_flag  = (st_q != ST_SEC_WAIT);
  assign stable_flag = (st_q == ST_RUN);

  // ---------------- Clock source select and divider ----------------
  logic [2:0]  pin_sync_q, pin_sync_d;
  logic [5:0]  div_q, div_d;
  logic [2:0]  act_sel_q, act_sel_d;
  logic [10:0] lf_cnt_q, lf_cnt_d;
  logic        tick_q, tick_d;
  logic        pin_rise, lf_tick;
  logic [5:0]  mask;

  assign pin_rise = pin_sync_q[1] & ~pin_sync_q[2];
  assign lf_tick  = (lf_cnt_q == 11'(LF_DIV_CYC - 1));
  // Code 7 passes every tick; each lower code down to 1 halves the rate again.
  // Code 1 needs the full 64-count wrap, so the shift is one less than the code.
  assign mask     = DIV_WRAP >> (act_sel_q - 3'h1);

  // Selection is taken only at the full divider wrap, where every divided rate has an edge,
  // so only a switch into code 0, whose counter runs free, can produce a runt period; high-frequency switches need no wait.
  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], CLOCK_INPUT_PIN};
    div_d      = div_q + 6'h01;
    lf_cnt_d   = lf_tick ? 11'h000 : lf_cnt_q + 11'h001;
    act_sel_d  = act_sel_q;
    if (div_q == DIV_WRAP) begin
      act_sel_d = fsel_q;
    end
    if (cfg_q[CFG_OSC_SRC]) begin
      tick_d = pin_rise;
    end else if (act_sel_q == FSEL_LF) begin
      tick_d = lf_tick;
    end else begin
      tick_d = ((div_q & mask) == mask);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_sync_q <= 3'h0;
      div_q      <= 6'h00;
      act_sel_q  <= FSEL_DEFAULT;
      lf_cnt_q   <= 11'h000;
      tick_q     <= 1'b0;
    end else begin
      pin_sync_q <= pin_sync_d;
      div_q      <= div_d;
      act_sel_q  <= act_sel_d;
      lf_cnt_q   <= lf_cnt_d;
      tick_q     <= tick_d;
    end
  end

  assign SYS_CLK_TICK = tick_q;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  logic first_q;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  sequence seq_pin_edge;
    cfg_q[CFG_OSC_SRC] && pin_sync_q[1] && !pin_sync_q[2];
  endsequence

  sequence seq_wdt_cause;
    cfg_q[CFG_WDT_LO +: 2] == EN_RUN_ONLY && SLEEP_MODE;
  endsequence

  AST_RESET_FSEL: assert property (first_q |-> fsel_q == FSEL_DEFAULT && act_sel_q == 3'h6)
    else $error("frequency select not at 8 MHz code after reset");
  AST_EXT_CLK: assert property (seq_pin_edge |-> ##1 SYS_CLK_TICK)
    else $error("external pin edge did not produce a system tick");
  AST_READY_FIRST: assert property (stable_flag |-> ready_flag)
    else $error("stable flag set without ready flag");
  AST_READY_TIME: assert property ($rose(ready_flag) |-> $past(st_cnt_q) == 32'(SEC_START_CYC - 1))
    else $error("ready flag rose at wrong count");
  AST_WDT_SLEEP: assert property (seq_wdt_cause ##1 $stable(cfg_q) |-> !WATCHDOG_EN)
    else $error("watchdog enabled in sleep under run-only code");
  AST_BOR_SW_IGNORED: assert property (cfg_q[CFG_BOR_LO +: 2] == 2'h0 |-> ##1 !BROWNOUT_EN || $changed(cfg_q))
    else $error("brown-out enabled under disabled code");
  AST_PWRT_LOW: assert property (##1 $stable(cfg_q) |-> POWERUP_TIMER_EN == !cfg_q[CFG_PWRT_N])
    else $error("power-up timer enable does not follow its active-low bit");
  AST_CP_READ: assert property (EXT_RD_REQ && !cfg_q[CFG_CP_N] |=> EXT_RD_DATA == 14'h0000)
    else $error("protected external read returned data");
  AST_SEL_BOUNDARY: assert property ($changed(act_sel_q) |-> $past(div_q) == DIV_WRAP)
    else $error("divider select changed off a boundary");
  AST_FAST_TICK: assert property (!cfg_q[CFG_OSC_SRC] && act_sel_q == FSEL_16M |=> SYS_CLK_TICK)
    else $error("16 MHz selection missed a tick");

endmodule // cwcs_top

// ===== logic/cwcs_pkg.sv
/*
  Constants shared by the configuration word and clock select block:
  register offsets, field positions, reset values, codes and timing counts.
  Assumes a 40 MHz reference clock that stands in for the high-frequency oscillator.
*/
package cwcs_pkg;
  // Reference clock rate and derived cycle counts.
  localparam int CLK_HZ          = 40_000_000;
  localparam int CLK_MHZ         = 40;
  localparam int SEC_START_NS    = 2000;            // Secondary clock start-up time.
  localparam int SEC_START_CYC   = (SEC_START_NS * CLK_MHZ + 999) / 1000;
  localparam int PRI_STABLE_US   = 1000;            // Primary clock settling time.
  localparam int PRI_STABLE_CYC  = PRI_STABLE_US * CLK_MHZ;
  localparam int LF_OSC_HZ       = 31_000;
  localparam int LF_DIV_CYC      = CLK_HZ / LF_OSC_HZ;

  // APB register byte offsets.
  localparam logic [7:0] OFS_CFG_WORD   = 8'h00;
  localparam logic [7:0] OFS_OSC_CTRL   = 8'h04;
  localparam logic [7:0] OFS_SW_ENABLE  = 8'h08;
  localparam logic [7:0] OFS_USER_ID0   = 8'h10;
  localparam logic [7:0] OFS_USER_ID3   = 8'h1C;

  // Configuration word layout.
  localparam int CFG_W           = 14;
  localparam int CFG_OSC_SRC     = 0;
  localparam int CFG_BOR_LO      = 1;
  localparam int CFG_WDT_LO      = 3;
  localparam int CFG_PWRT_N      = 5;
  localparam int CFG_CP_N        = 7;
  localparam int CFG_WRT_LO      = 11;
  localparam logic [13:0] CFG_ERASED = 14'h3FFF;

  // Oscillator control layout and reset value.
  localparam int OSC_FSEL_LO     = 4;
  localparam int OSC_READY_BIT   = 3;
  localparam int OSC_STABLE_BIT  = 0;
  localparam logic [2:0] FSEL_DEFAULT = 3'h6;   // 8 MHz after any reset.
  localparam logic [2:0] FSEL_LF      = 3'h0;   // Low-frequency oscillator.
  localparam logic [2:0] FSEL_16M     = 3'h7;

  // Software enable register layout.
  localparam int SW_WDT_BIT      = 0;
  localparam int SW_BOR_BIT      = 1;

  // Two-bit enable field codes shared by watchdog and brown-out.
  localparam logic [1:0] EN_ALWAYS   = 2'h3;
  localparam logic [1:0] EN_RUN_ONLY = 2'h2;
  localparam logic [1:0] EN_SOFTWARE = 2'h1;

  localparam int DIV_W           = 6;
  localparam logic [5:0] DIV_WRAP = 6'h3F;
  localparam int USER_ID_NUM     = 4;
endpackage

// ===== verif/cwcs_ext_clk_src.sv
/*
  Model of the external clock source that drives the clock input pin.
  Assumes the bench calls run() from its own process; between frames the pin stands low.
*/
`timescale 1ns/1ps
module cwcs_ext_clk_src (
  output logic clk_pin
);
  initial clk_pin = 1'b0;

  // Drives a logic-level clock of n periods, then parks the pin low.
  task automatic run(input int n, input int half_ns);
    repeat (n) begin
      #(half_ns) clk_pin = 1'b1;
      #(half_ns) clk_pin = 1'b0;
    end
  endtask
endmodule // cwcs_ext_clk_src

// ===== verif/test_config_word_clock_select.sv
/*
  Self-checking bench for the configuration word and clock select block.
  Assumes zero-wait APB answers may come at any edge and PRI_CYC is cut to 200.
*/
`timescale 1ns/1ps
module test_config_word_clock_select;
  import cwcs_pkg::*;
  localparam int PRI = 200;
  logic REF_CLK, RST_N, PSEL, PENABLE, PWRITE, BULK_ERASE, SLEEP_MODE;
  logic EXT_RD_REQ, EXT_WR_REQ, PREADY, PSLVERR, EXT_WR_GO, SYS_CLK_TICK, CLOCK_INPUT_PIN_IS_GPIO;
  logic WATCHDOG_EN, BROWNOUT_EN, POWERUP_TIMER_EN, CLOCK_INPUT_PIN;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, v;
  logic [13:0] CFG_STRAP, EXT_RD_MEM, EXT_RD_DATA, s;
  logic [1:0]  WRITE_PROTECT_SIZE;
  logic [31:0] apb_q[$];
  logic [13:0] ext_q[$];
  logic rd_pend, err_seen;
  int bad_count, compares, seed, g, nt, np;

  cwcs_top #(.PRI_CYC(PRI)) cwcs_top_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CFG_STRAP(CFG_STRAP), .BULK_ERASE(BULK_ERASE),
    .CLOCK_INPUT_PIN(CLOCK_INPUT_PIN), .SLEEP_MODE(SLEEP_MODE), .EXT_RD_REQ(EXT_RD_REQ),
    .EXT_RD_MEM(EXT_RD_MEM), .EXT_WR_REQ(EXT_WR_REQ), .EXT_RD_DATA(EXT_RD_DATA),
    .EXT_WR_GO(EXT_WR_GO), .SYS_CLK_TICK(SYS_CLK_TICK), .CLOCK_INPUT_PIN_IS_GPIO(CLOCK_INPUT_PIN_IS_GPIO),
    .WATCHDOG_EN(WATCHDOG_EN), .BROWNOUT_EN(BROWNOUT_EN),
    .POWERUP_TIMER_EN(POWERUP_TIMER_EN), .WRITE_PROTECT_SIZE(WRITE_PROTECT_SIZE));
  cwcs_ext_clk_src cwcs_ext_clk_src_i (.clk_pin(CLOCK_INPUT_PIN));

  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    compares++;
    if (a !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, a);
    end
  endtask

  // Watcher: every result that appears is matched with the oldest note.
  always @(posedge REF_CLK) begin
    rd_pend <= EXT_RD_REQ;
    if (PSEL && PENABLE && PREADY && !PWRITE) chk("prdata", apb_q.pop_front(), PRDATA);
    if (rd_pend) chk("ext_rd_data", {18'h0, ext_q.pop_front()}, {18'h0, EXT_RD_DATA});
  end

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d; PENABLE <= 1'b0;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    err_seen = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
    // One idle edge, so a following call never re-drives psel in this time step.
    @(posedge REF_CLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic ext_rd(input logic [13:0] m, input logic [13:0] e);
    EXT_RD_REQ <= 1'b1; EXT_RD_MEM <= m; ext_q.push_back(e);
    @(posedge REF_CLK);
    EXT_RD_REQ <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic do_reset(input logic [13:0] st);
    RST_N <= 1'b0; CFG_STRAP <= st;
    repeat (4) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
  endtask

  // Cycles between two consecutive system clock ticks.
  task automatic tick_gap(output int n);
    n = 0;
    while (SYS_CLK_TICK !== 1'b1 && n < 3000) begin @(posedge REF_CLK); n++; end
    n = 0;
    do begin @(posedge REF_CLK); n++; end while (SYS_CLK_TICK !== 1'b1 && n < 3000);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge REF_CLK);
    bad_count++;
    final_report();
  end

  initial begin
    seed = 32'hB348;
    {RST_N, PSEL, PENABLE, PWRITE, BULK_ERASE, SLEEP_MODE, EXT_RD_REQ, EXT_WR_REQ} = 8'h0;
    {PADDR, PWDATA, EXT_RD_MEM, rd_pend} = '0;
    CFG_STRAP = CFG_ERASED;
    // Internal oscillator mode, so the divider scenario sees internal ticks.
    s = CFG_ERASED;
    s[CFG_OSC_SRC] = 1'b0;
    do_reset(s);
    rd(OFS_OSC_CTRL, 32'h60);
    repeat (SEC_START_CYC) @(posedge REF_CLK);
    rd(OFS_OSC_CTRL, 32'h68);
    repeat (PRI) @(posedge REF_CLK);
    rd(OFS_OSC_CTRL, 32'h69);
    $display("test startup done");
    // Every select code, switched with no restart between them.
    for (int c = 7; c >= 0; c--) begin
      apb(1'b1, OFS_OSC_CTRL, 32'(c) << OSC_FSEL_LO);
      repeat (70) @(posedge REF_CLK);
      tick_gap(g);
      chk("tick_gap", (c == 0) ? LF_DIV_CYC : (1 << (7 - c)), g);
      rd(OFS_OSC_CTRL, (32'(c) << OSC_FSEL_LO) | 32'h9);
    end
    $display("test divider done");
    for (int i = 0; i < 4; i++) begin
      s = CFG_ERASED;
      s[CFG_WDT_LO +: 2] = 2'(i);
      s[CFG_BOR_LO +: 2] = 2'(i);
      s[CFG_WRT_LO +: 2] = 2'(i);
      s[CFG_PWRT_N] = i[1];
      s[CFG_OSC_SRC] = i[0];
      do_reset(s);
      rd(OFS_OSC_CTRL, 32'h60);
      rd(OFS_CFG_WORD, {18'h0, s});
      chk("clock_input_pin_is_gpio", !i[0], CLOCK_INPUT_PIN_IS_GPIO);
      chk("wp_size", i, WRITE_PROTECT_SIZE);
      chk("pwrt_en", !i[1], POWERUP_TIMER_EN);
      for (int k = 0; k < 2; k++) begin
        SLEEP_MODE <= k[0];
        apb(1'b1, OFS_SW_ENABLE, 32'(k * 3));
        repeat (2) @(posedge REF_CLK);
        v = 32'(i == 3 || (i == 2 && k == 0) || (i == 1 && k == 1));
        chk("wdt_en", v, WATCHDOG_EN);
        chk("bor_en", v, BROWNOUT_EN);
      end
      SLEEP_MODE <= 1'b0;
    end
    $display("test decode done");
    // External source: one tick per pin rise, none once the pin stops.
    s = CFG_ERASED;
    do_reset(s);
    nt = 0;
    fork
      cwcs_ext_clk_src_i.run(20, 100);
      repeat (180) begin @(posedge REF_CLK); nt += (SYS_CLK_TICK === 1'b1); end
    join
    chk("ext_ticks", 20, nt);
    $display("test external done");
    for (int i = 0; i < USER_ID_NUM; i++) begin
      v = {18'h0, 14'($random(seed))};
      apb(1'b1, 8'(OFS_USER_ID0 + 4 * i), v);
      rd(8'(OFS_USER_ID0 + 4 * i), v);
    end
    rd(8'h40, 32'h0);
    chk("pslverr", 1, err_seen);
    apb(1'b1, OFS_CFG_WORD, 32'h0);
    rd(OFS_CFG_WORD, {18'h0, s});
    $display("test registers done");
    s[CFG_CP_N] = 1'b0;
    do_reset(s);
    v = 32'($random(seed));
    ext_rd(v[13:0], 14'h0);
    EXT_WR_REQ <= 1'b1;
    @(posedge REF_CLK);
    chk("ext_wr_go", 0, EXT_WR_GO);
    rd(OFS_OSC_CTRL, 32'h60);
    BULK_ERASE <= 1'b1;
    @(posedge REF_CLK);
    BULK_ERASE <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    chk("ext_wr_go", 1, EXT_WR_GO);
    @(posedge REF_CLK);
    EXT_WR_REQ <= 1'b0;
    ext_rd(v[13:0], v[13:0]);
    rd(OFS_CFG_WORD, {18'h0, CFG_ERASED});
    $display("test protect done");
    repeat (2) @(posedge REF_CLK);
    final_report();
  end
endmodule // test_config_word_clock_select
